// ===== rtl/rbc_pkg.sv
package rbc_pkg;

  typedef enum logic [2:0] {
    MODE_TYPE_A,
    MODE_TYPE_ONE,
    MODE_TYPE_THREE,
    MODE_TYPE_B,
    MODE_VICINITY
  } rbc_mode_type;

  // Rate code: 0=106, 1=212, 2=424, 3=848 kbit/s
  typedef logic [1:0] rbc_rate_type;

  localparam int unsigned       RBC_NUM_MODES    = 5;
  localparam logic [9:0]        RBC_PERIOD_106   = 10'h080;
  localparam logic [9:0]        RBC_PERIOD_VIC   = 10'h200;
  localparam logic [9:0]        RBC_SUBCARRIER   = 10'h010;
  // Vicinity gap length, and last count of a two-bit symbol of two bit periods
  localparam logic [7:0]        RBC_VIC_GAP      = 8'h20;
  localparam logic [9:0]        RBC_VIC_SYM_LAST = 10'h3FF;
  localparam rbc_rate_type      RBC_RATE_106     = 2'h0;
  localparam rbc_rate_type      RBC_RATE_212     = 2'h1;
  localparam rbc_rate_type      RBC_RATE_424     = 2'h2;
  localparam rbc_rate_type      RBC_RATE_848     = 2'h3;
  localparam logic [1:0]        RBC_VIC_SLOTS    = 2'h3;
  localparam logic [3:0]        RBC_INV_SLOTS    = 4'hF;

  // Transmit request: a frame of up to 8 bits at a time, MSB first
  typedef struct packed {
    logic         valid;
    rbc_mode_type mode;
    rbc_rate_type rate;
    logic [7:0]   data;
    logic [3:0]   nbits;
  } rbc_tx_req_type;

  typedef struct packed {
    logic       valid;
    logic       bit_val;
    logic       error;
  } rbc_rx_out_type;

endpackage

// ===== rtl/rbc_reader_bit_coding.sv
`timescale 1ns/1ps
// Functional notes
// - Five reader modes: type A, type one, type three, type B, vicinity.
// - Type A sends Modified Miller 106-848k; decodes Manchester 106k, BPSK above.
// - Type three uses Manchester both ways at 212/424k, no subcarrier.
// - Type B sends NRZ, decodes BPSK on carrier/16, 106 to 848k.
// - Vicinity mode only 26.48k, single subcarrier.
// - Vicinity transmit uses pulse position, full-depth gaps.
// - Vicinity responses decoded as Manchester subcarrier modulation.
// - Vicinity inventory slots step at the end of each vicinity frame sent.
// - Vicinity uses one-out-of-four PPM, 512 carrier cycles per bit.
module rbc_reader_bit_coding
  import rbc_pkg::*;
#(
  parameter int unsigned SLOT_COUNT = 16
)
(
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire rbc_tx_req_type txReq,
  input  wire logic           inventoryStart,
  input  wire logic           rxPin,
  output logic                txReady,
  output logic                carrierOff,
  output logic                subcarrierRef,
  output rbc_rx_out_type      rxOut,
  output logic [3:0]          inventorySlot,
  output logic                inventoryBusy
);

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} rbc_state_type;

  typedef struct packed {
    rbc_state_type state;
    rbc_mode_type  mode;
    rbc_rate_type  rate;
    logic [7:0]    shreg;
    logic [3:0]    bitsLeft;
    logic [9:0]    cnt;
    logic          prevBit;
    logic [3:0]    subCnt;
    logic          carrierOff;
    logic          txReady;
    logic [2:0]    rxSync;
    logic          rxHalf1;
    logic          rxRef;
    logic [9:0]    rxCnt;
    rbc_rx_out_type rxOut;
    logic [3:0]    slot;
    logic          invBusy;
  } rbc_regs_type;

  rbc_regs_type r_r;
  rbc_regs_type r_nxt;

  // Slots are numbered on a four-bit output
  if (SLOT_COUNT < 1 || SLOT_COUNT > 16) begin : gSlotCheck
    $error("SLOT_COUNT must lie between 1 and 16");
  end

  function automatic logic [9:0] bitPeriod(rbc_mode_type m, rbc_rate_type rt);
    if (m == MODE_VICINITY) begin
      return RBC_PERIOD_VIC;
    end
    return RBC_PERIOD_106 >> rt;
  endfunction

  logic [9:0] period;
  logic [9:0] half;
  logic [9:0] quarter;
  logic       rxStable;
  logic       rxLevel;
  logic [9:0] symLast;

  always_comb begin
    period   = bitPeriod(r_r.mode, r_r.rate);
    half     = period >> 1;
    quarter  = period >> 2;
    // A vicinity symbol carries two bits, so it spans two bit periods
    symLast  = (r_r.mode == MODE_VICINITY) ? RBC_VIC_SYM_LAST : period - 10'h001;
    rxStable = (r_r.rxSync[1] == r_r.rxSync[2]);
    rxLevel  = r_r.rxSync[2];
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.rxOut.valid = 1'b0;
    r_nxt.rxOut.error = 1'b0;
    r_nxt.rxSync = {r_r.rxSync[1:0], rxPin};
    // Subcarrier reference at carrier/16, free running
    r_nxt.subCnt = r_r.subCnt + 4'h1;
    case (r_r.state)
      ST_IDLE: begin
        r_nxt.carrierOff = 1'b0;
        r_nxt.txReady    = 1'b1;
        // Taken only while txReady shows high, as the requester sees it
        if (r_r.txReady && txReq.valid && txReq.nbits != 4'h0) begin
          // Mode and rate frozen for the whole frame
          r_nxt.mode     = txReq.mode;
          r_nxt.rate     = (txReq.mode == MODE_VICINITY) ? RBC_RATE_106 : txReq.rate;
          // Type three runs only at 212 or 424k; other rates are clamped
          if (txReq.mode == MODE_TYPE_THREE && txReq.rate == RBC_RATE_106) begin
            r_nxt.rate = RBC_RATE_212;
          end else if (txReq.mode == MODE_TYPE_THREE && txReq.rate == RBC_RATE_848) begin
            r_nxt.rate = RBC_RATE_424;
          end
          r_nxt.shreg    = txReq.data;
          r_nxt.bitsLeft = txReq.nbits;
          r_nxt.cnt      = 10'h000;
          r_nxt.prevBit  = 1'b0;
          r_nxt.txReady  = 1'b0;
          r_nxt.state    = ST_TX;
        end
      end
      ST_TX: begin
        r_nxt.cnt = r_r.cnt + 10'h001;
        case (r_r.mode)
          MODE_TYPE_A, MODE_TYPE_ONE: begin
            // Modified Miller: pause mid-bit for 1, at start for 0 after 0
            if (r_r.shreg[7]) begin
              r_nxt.carrierOff = (r_r.cnt >= half) && (r_r.cnt < half + quarter);
            end else begin
              r_nxt.carrierOff = !r_r.prevBit && (r_r.cnt < quarter);
            end
          end
          MODE_TYPE_THREE: begin
            r_nxt.carrierOff = (r_r.cnt < half) ? r_r.shreg[7] : !r_r.shreg[7];
          end
          MODE_TYPE_B: begin
            r_nxt.carrierOff = !r_r.shreg[7];
          end
          MODE_VICINITY: begin
            // Two bits pick one of four slots; a full gap in that slot
            r_nxt.carrierOff = (r_r.cnt[9:8] == r_r.shreg[7:6]) &&
                               (r_r.cnt[7:0] < RBC_VIC_GAP);
          end
          default: r_nxt.carrierOff = 1'b0;
        endcase
        if (r_r.cnt == symLast) begin
          r_nxt.cnt     = 10'h000;
          r_nxt.prevBit = r_r.shreg[7];
          if (r_r.mode == MODE_VICINITY) begin
            r_nxt.shreg    = {r_r.shreg[5:0], 2'b00};
            r_nxt.bitsLeft = (r_r.bitsLeft > 4'h1) ? r_r.bitsLeft - 4'h2 : 4'h0;
          end else begin
            r_nxt.shreg    = {r_r.shreg[6:0], 1'b0};
            r_nxt.bitsLeft = r_r.bitsLeft - 4'h1;
          end
          if (r_nxt.bitsLeft == 4'h0) begin
            r_nxt.carrierOff = 1'b0;
            r_nxt.rxCnt      = 10'h000;
            r_nxt.state      = ST_RX;
          end
        end
      end
      ST_RX: begin
        // Symbol timing runs from the end of the frame; no start-of-frame search
        // One symbol per bit period; halves compared for Manchester, first-half level against subCnt[3] for BPSK
        if (rxStable) begin
          r_nxt.rxCnt = r_r.rxCnt + 10'h001;
          if (r_r.rxCnt == quarter) begin
            r_nxt.rxHalf1 = rxLevel ^ ((r_r.mode == MODE_TYPE_B ||
                            (r_r.mode == MODE_TYPE_A && r_r.rate != RBC_RATE_106))
                            ? r_r.subCnt[3] : 1'b0);
          end
          if (r_r.rxCnt == half + quarter) begin
            r_nxt.rxOut.valid = 1'b1;
            if (r_r.mode == MODE_TYPE_B ||
                (r_r.mode == MODE_TYPE_A && r_r.rate != RBC_RATE_106)) begin
              r_nxt.rxOut.bit_val = r_r.rxHalf1;
            end else begin
              // Manchester: halves must differ
              r_nxt.rxOut.bit_val = r_r.rxHalf1;
              r_nxt.rxOut.error   = (r_r.rxHalf1 == rxLevel);
            end
          end
          if (r_r.rxCnt == period - 10'h001) begin
            r_nxt.rxCnt = 10'h000;
          end
        end
        // New frame ends reception; the far side has fallen silent by then
        if (txReq.valid) begin
          r_nxt.state = ST_IDLE;
        end
      end
      default: r_nxt.state = ST_IDLE;
    endcase
    // Inventory slots advance at each transmitted vicinity end-of-frame
    if (inventoryStart && !r_r.invBusy) begin
      r_nxt.invBusy = 1'b1;
      r_nxt.slot    = 4'h0;
    end else if (r_r.invBusy && r_r.state == ST_TX && r_nxt.state == ST_RX &&
                 r_r.mode == MODE_VICINITY) begin
      if (r_r.slot == 4'(SLOT_COUNT - 1)) begin
        r_nxt.invBusy = 1'b0;
      end else begin
        r_nxt.slot = r_r.slot + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign txReady       = r_r.txReady;
  assign carrierOff    = r_r.carrierOff;
  assign subcarrierRef = r_r.subCnt[3];
  assign rxOut         = r_r.rxOut;
  assign inventorySlot = r_r.slot;
  assign inventoryBusy = r_r.invBusy;

endmodule

// ===== bench/rbc_chk.sv
`timescale 1ns/1ps
module rbc_chk
  import rbc_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire rbc_tx_req_type txReq,
  input wire logic           inventoryStart,
  input wire logic           txReady,
  input wire logic           carrierOff,
  input wire logic           subcarrierRef,
  input wire rbc_rx_out_type rxOut,
  input wire logic [3:0]     inventorySlot,
  input wire logic           inventoryBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sub_half; subcarrierRef [*8] ##1 !subcarrierRef; endsequence
  take_fall_a: assert property (
    txReady && txReq.valid && txReq.nbits != 4'h0 |=> !txReady) else $error("no busy");
  idle_quiet_a: assert property (
    txReady |-> !carrierOff) else $error("idle gap");
  rx_pulse_a: assert property (
    rxOut.valid |=> !rxOut.valid) else $error("long valid");
  subc_half_a: assert property (
    $rose(subcarrierRef) |-> sub_half) else $error("bad subcarrier");
  err_rx_a: assert property (
    rxOut.error |-> !txReady ##1 !rxOut.error) else $error("bad error");
  slot_step_a: assert property (
    inventoryBusy && $changed(inventorySlot) |-> inventorySlot == $past(inventorySlot) + 4'h1)
    else $error("slot skip");
  inv_end_a: assert property (
    $fell(inventoryBusy) |-> $past(inventorySlot) == RBC_INV_SLOTS) else $error("short run");
  inv_start_a: assert property (
    inventoryStart && !inventoryBusy |-> ##[1:2] inventoryBusy) else $error("no start");
endmodule
bind rbc_reader_bit_coding rbc_chk u_chk (.clk, .rst, .txReq, .inventoryStart, .txReady,
  .carrierOff, .subcarrierRef, .rxOut, .inventorySlot, .inventoryBusy);

// ===== bench/rbc_tag_model.sv
`timescale 1ns/1ps
module rbc_tag_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] data,
  input  wire logic       bad,
  output logic            rxPin
);
  // Half of the 512-cycle vicinity bit
  localparam int HALF = 256;
  initial rxPin = 1'b0;
  // Bad keeps one bit flat to fake a coding slip
  always @(posedge go) begin
    for (int i = 7; i >= 0; i--) begin
      rxPin = data[i];
      repeat (HALF) @(posedge clk);
      #1;
      rxPin = (bad && i == 4) ? data[i] : !data[i];
      repeat (HALF) @(posedge clk);
      #1;
    end
    rxPin = 1'b0;
  end
endmodule

// ===== bench/rbc_reader_bit_coding_tb.sv
`timescale 1ns/1ps
module rbc_reader_bit_coding_tb
  import rbc_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           inventoryStart = 1'b0;
  logic           go = 1'b0;
  logic           bad = 1'b0;
  logic [7:0]     rxData = 8'h00;
  rbc_tx_req_type txReq = '0;
  logic           rxPin, txReady, carrierOff, subcarrierRef, inventoryBusy;
  logic [3:0]     inventorySlot;
  rbc_rx_out_type rxOut;
  int             error_cnt = 0;
  int             samples_checked = 0;
  int             rises[$];
  int             gap;
  always #2.5 clk = ~clk;
  rbc_reader_bit_coding u_rbc_reader_bit_coding (.clk, .rst, .txReq, .inventoryStart, .rxPin,
    .txReady, .carrierOff, .subcarrierRef, .rxOut, .inventorySlot, .inventoryBusy);
  rbc_tag_model u_rbc_tag_model (.clk, .go, .data(rxData), .bad, .rxPin);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 40000) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // Request held until taken; a request in receive ends reception first
  task automatic frame(rbc_mode_type m, rbc_rate_type r, logic [7:0] d, logic [3:0] nb, int w);
    int   n;
    logic prev;
    n = 0;
    prev = 1'b0;
    rises = {};
    gap = 0;
    txReq = '{1'b1, m, r, d, nb};
    while (txReady !== 1'b1) step(n);
    step(n);
    txReq.valid = 1'b0;
    repeat (w) begin
      if (carrierOff && !prev) rises.push_back(n);
      if (carrierOff && rises.size() == 1) gap++;
      prev = carrierOff;
      step(n);
    end
  endtask
  task automatic t_type_a();
    for (int r = 0; r < 4; r++) begin
      frame(MODE_TYPE_A, rbc_rate_type'(r), 8'hFF, 4'h8, 8 * (128 >> r));
      check("miller", 16'(rises[2] - rises[1]), 16'(RBC_PERIOD_106 >> r));
    end
  endtask
  task automatic t_others();
    frame(MODE_TYPE_THREE, RBC_RATE_106, 8'hFF, 4'h8, 520);
    check("manch", 16'(rises[2] - rises[1]), 16'h40);
    frame(MODE_TYPE_THREE, RBC_RATE_848, 8'hFF, 4'h8, 260);
    check("manch424", 16'(rises[2] - rises[1]), 16'h20);
    frame(MODE_TYPE_B, RBC_RATE_848, 8'hA5, 4'h8, 128);
    check("nrz", 16'(rises[1] - rises[0]), 16'h20);
    frame(MODE_TYPE_ONE, RBC_RATE_106, 8'hA5, 4'h8, 1024);
    check("t1", 16'(rises.size() != 0), 16'h1);
    check("t1zero", 16'(rises[2] - rises[1]), 16'hC0);
    frame(MODE_VICINITY, RBC_RATE_848, 8'h1B, 4'h8, 4096);
    check("ppm", 16'(rises[2] - rises[1]), 16'h500);
    check("gap", 16'(gap), 16'h20);
  endtask
  task automatic t_subc();
    int   n;
    logic s;
    n = 0;
    s = subcarrierRef;
    repeat (8) step(n);
    check("subchalf", {15'h0, subcarrierRef}, {15'h0, !s});
    repeat (8) step(n);
    check("subcfull", {15'h0, subcarrierRef}, {15'h0, s});
  endtask
  task automatic t_rx(logic [7:0] d, logic b);
    int         n;
    int         errs;
    logic [7:0] v;
    n = 0;
    errs = 0;
    v = 8'h00;
    frame(MODE_VICINITY, RBC_RATE_106, 8'h1B, 4'h8, 4096);
    rxData = d;
    bad = b;
    go = 1'b1;
    repeat (4200) begin
      if (rxOut.valid === 1'b1) v = {v[6:0], rxOut.bit_val};
      if (rxOut.error === 1'b1) errs++;
      step(n);
      go = 1'b0;
    end
    if (!b) check("rxbits", {8'h00, v}, {8'h00, d});
    check("rxerr", 16'(errs != 0), 16'(b));
  endtask
  task automatic t_inv();
    int n;
    n = 0;
    inventoryStart = 1'b1;
    step(n);
    inventoryStart = 1'b0;
    check("invbusy", {15'h0, inventoryBusy}, 16'h1);
    for (int k = 1; k <= 16; k++) begin
      frame(MODE_VICINITY, RBC_RATE_106, 8'h00, 4'h2, 1024);
      check("invslot", {12'h0, inventorySlot}, 16'(k < 16 ? k : 15));
      check("invrun", {15'h0, inventoryBusy}, 16'(k < 16));
    end
    while (inventoryBusy !== 1'b0) step(n);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    check("ready", {15'h0, txReady}, 16'h1);
    t_type_a();
    t_others();
    t_subc();
    t_rx(8'hC6, 1'b0);
    t_rx(8'h3A, 1'b1);
    t_inv();
    finish_test();
  end
endmodule
